// ### rtl/emcs_pkg.sv
// Shared types and constants for the external memory cycle sequencer.
package emcs_pkg;

  // Core clock: one period is one half clock unit of the bus.
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_CLOCK_UNIT_NS = 10;
  localparam int HALF_CLOCK_UNIT_CYC =
    (HALF_CLOCK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROC_CLOCK_PERIOD_NS = 2 * HALF_CLOCK_UNIT_NS;
  // Multiplier between the input clock and the processor clock output.
  localparam int PLL_MULTIPLIER = 5;
  localparam int INPUT_CLOCK_PERIOD_NS = PROC_CLOCK_PERIOD_NS * PLL_MULTIPLIER;

  // Bus and configuration geometry.
  localparam int ADDR_W = 30;
  localparam int DATA_W = 32;
  localparam int LEN_W = 3;
  localparam int NUM_PHASES = 6;
  localparam int NUM_BUILTIN = 13;
  localparam int SEL_W = 4;
  localparam logic [LEN_W-1:0] LEN_MIN = 3'h1;
  localparam logic [LEN_W-1:0] LEN_MAX = 3'h4;
  localparam logic [1:0] STRAP_CAPTURE = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  // Phase lengths in half clock units; element 0 is the first phase.
  typedef logic [NUM_PHASES-1:0][LEN_W-1:0] emcs_lens_t;
  localparam emcs_lens_t RESET_LENS = {NUM_PHASES{LEN_MAX}};

  typedef enum logic [2:0] {
    PH_IDLE, PH_T1, PH_T2, PH_T3, PH_T4, PH_T5, PH_T6, PH_PAD
  } emcs_phase_t;

  // One external cycle request from the core.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] byte_en;
    logic write;
    logic refresh;
  } emcs_req_t;

  // Internal access shown on the bus while no external cycle runs.
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic write;
  } emcs_int_t;

  // Everything the block drives onto its pins.
  typedef struct packed {
    logic [ADDR_W-1:0] ad;
    logic ad_oe;
    logic wf;
    logic wf_oe;
    logic rf;
    logic rf_oe;
    logic rd_n;
    logic av_n;
    logic [3:0] wr_n;
    logic pclk;
  } emcs_pins_t;

  localparam emcs_pins_t PINS_RESET = '{
    ad: '0, ad_oe: 1'b0, wf: 1'b1, wf_oe: 1'b0, rf: 1'b1, rf_oe: 1'b0,
    rd_n: 1'b1, av_n: 1'b1, wr_n: 4'hf, pclk: 1'b0};

endpackage

// ### rtl/emcs_buf2.sv
// Two-entry buffer with registered outputs for read data.
`timescale 1ns/100ps
`default_nettype none

module emcs_buf2 (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [emcs_pkg::DATA_W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [emcs_pkg::DATA_W-1:0] out_data_o
);

  typedef struct packed {
    logic hv;
    logic [emcs_pkg::DATA_W-1:0] hd;
    logic tv;
    logic [emcs_pkg::DATA_W-1:0] td;
    logic rdy;
  } emcs_buf_state_t;

  emcs_buf_state_t s_r;
  emcs_buf_state_t s_nxt;

  // The head always sits in a register, so the receiver sees flop outputs;
  // the tail only fills while the receiver stalls.
  always_comb
  begin
    s_nxt = s_r;
    if (s_r.hv && out_ready_i)
    begin
      s_nxt.hv = s_r.tv;
      s_nxt.hd = s_r.td;
      s_nxt.tv = 1'b0;
    end
    if (in_valid_i && s_r.rdy)
    begin
      if (!s_nxt.hv)
      begin
        s_nxt.hv = 1'b1;
        s_nxt.hd = in_data_i;
      end
      else
      begin
        s_nxt.tv = 1'b1;
        s_nxt.td = in_data_i;
      end
    end
    s_nxt.rdy = !s_nxt.tv;
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_r <= '{hv: 1'b0, hd: '0, tv: 1'b0, td: '0, rdy: 1'b1};
    else
      s_r <= s_nxt;
  end

  assign in_ready_o = s_r.rdy;
  assign out_valid_o = s_r.hv;
  assign out_data_o = s_r.hd;

endmodule

`default_nettype wire

// ### rtl/emcs_sequencer.sv
// External memory cycle sequencer: phases, strobes and bus multiplexing.
// Notes on behaviour
// - Processor clock period is input clock period divided by the multiplier.
// - Timing unit is half a processor clock period; phases count in it.
// - Every strobe edge lands on a processor clock output edge.
// - Each external cycle runs six phases in fixed order.
// - Each phase lasts one to four half clock units.
// - After reset all phases last four units.
// - Wait requests stretch phase four without limit at its end.
// - Cycles are an even unit count; phase one starts on rising clock.
// - Odd totals, wait units included, get one padding unit after phase six.
// - A strap selects one of 13 built-in timings or a user timing.
// - Internal accesses show address and direction; refresh flag high.
// - Refresh or memory request cycles override the internal display.
// - Only upper 30 address bits are driven, in phases one and two.
// - Reads select bytes internally; writes use four byte strobes.
// - Data bus is address pins plus refresh and write flag pins.
// - Write data driven from phase three through six and padding.
// - Write flag low for writes in phases one, two; then data bit 0.
// - Refresh flag low for refresh in phases one, two; then bit 1.
// - Read strobe low in phases four and five; data sampled at its rise; the word pushed there is the bus value taken two units earlier.
// - Address valid strobe low from phase two through phase five.
`timescale 1ns/100ps
`default_nettype none

module emcs_sequencer (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [emcs_pkg::SEL_W-1:0] cfg_sel_i,
  input wire emcs_pkg::emcs_lens_t cfg_user_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire emcs_pkg::emcs_req_t req_i,
  input wire emcs_pkg::emcs_int_t int_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [emcs_pkg::DATA_W-1:0] rd_data_o,
  input wire logic wait_i,
  input wire logic [emcs_pkg::ADDR_W-1:0] mux_addr_data_bus_i,
  output logic [emcs_pkg::ADDR_W-1:0] mux_addr_data_bus_o,
  output logic mux_addr_data_bus_oe_o,
  input wire logic write_flag_data0_i,
  output logic write_flag_data0_o,
  output logic write_flag_data0_oe_o,
  input wire logic refresh_flag_data1_i,
  output logic refresh_flag_data1_o,
  output logic refresh_flag_data1_oe_o,
  output logic read_strobe_n_o,
  output logic address_valid_strobe_n_o,
  output logic [3:0] byte_write_strobes_n_o,
  output logic processor_clock_output_o
);

  typedef struct packed {
    emcs_pkg::emcs_phase_t phase;
    logic [emcs_pkg::LEN_W-1:0] cnt;
    emcs_pkg::emcs_lens_t lens;
    emcs_pkg::emcs_lens_t pend_lens;
    logic pend_valid;
    logic [1:0] strap_cnt;
    logic [emcs_pkg::SEL_W-1:0] sel_s1;
    logic [emcs_pkg::SEL_W-1:0] sel_s2;
    logic wait_s1;
    logic wait_s2;
    logic [emcs_pkg::DATA_W-1:0] din_s1;
    logic [emcs_pkg::DATA_W-1:0] din_s2;
    emcs_pkg::emcs_req_t req;
    logic rdy;
    emcs_pkg::emcs_pins_t pins;
  } emcs_state_t;

  emcs_state_t s_r;
  emcs_state_t s_nxt;
  logic push;
  logic buf_ready;

  // Builds one timing set from six phase lengths, first phase first.
  function automatic emcs_pkg::emcs_lens_t mk_lens(
    input logic [emcs_pkg::LEN_W-1:0] t1, t2, t3, t4, t5, t6);
    mk_lens = {t6, t5, t4, t3, t2, t1};
  endfunction

  // Built-in timings chosen by the strap; codes above 12 take the user set.
  function automatic emcs_pkg::emcs_lens_t builtin_lens(
    input logic [emcs_pkg::SEL_W-1:0] sel, input emcs_pkg::emcs_lens_t user);
    unique case (sel)
      4'h0: builtin_lens = mk_lens(3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1);
      4'h1: builtin_lens = mk_lens(3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h1);
      4'h2: builtin_lens = mk_lens(3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h1);
      4'h3: builtin_lens = mk_lens(3'h1, 3'h2, 3'h1, 3'h2, 3'h2, 3'h1);
      4'h4: builtin_lens = mk_lens(3'h2, 3'h1, 3'h2, 3'h2, 3'h1, 3'h2);
      4'h5: builtin_lens = mk_lens(3'h1, 3'h2, 3'h2, 3'h3, 3'h2, 3'h1);
      4'h6: builtin_lens = mk_lens(3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2);
      4'h7: builtin_lens = mk_lens(3'h2, 3'h2, 3'h2, 3'h3, 3'h2, 3'h2);
      4'h8: builtin_lens = mk_lens(3'h2, 3'h2, 3'h3, 3'h3, 3'h2, 3'h3);
      4'h9: builtin_lens = mk_lens(3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3);
      4'ha: builtin_lens = mk_lens(3'h3, 3'h3, 3'h3, 3'h4, 3'h3, 3'h3);
      4'hb: builtin_lens = mk_lens(3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3);
      4'hc: builtin_lens = mk_lens(3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4);
      default: builtin_lens = user;
    endcase
  endfunction

  // Read data leave through a two-entry buffer so a stalled core loses none.
  emcs_buf2 u_rd_buf (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .in_valid_i(push),
    .in_ready_o(buf_ready), .in_data_i(s_r.din_s2),
    .out_valid_o(rd_valid_o), .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o));

  // Next state: synchronisers, strap, phase sequence, then the pins.
  always_comb
  begin
    s_nxt = s_r;
    push = 1'b0;
    s_nxt.sel_s1 = cfg_sel_i;
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.wait_s1 = wait_i;
    s_nxt.wait_s2 = s_r.wait_s1;
    s_nxt.din_s1 = {mux_addr_data_bus_i, refresh_flag_data1_i,
                    write_flag_data0_i};
    s_nxt.din_s2 = s_r.din_s1;
    // The processor clock toggles every unit, so every unit edge is
    // a clock edge and every strobe edge falls on one.
    s_nxt.pins.pclk = !s_r.pins.pclk;
    // The strap is read once it has crossed both flops; the reset timing
    // stays in force until the first cycle boundary after that.
    if (s_r.strap_cnt != emcs_pkg::STRAP_DONE)
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
    if (s_r.strap_cnt == emcs_pkg::STRAP_CAPTURE)
    begin
      s_nxt.pend_lens = builtin_lens(s_r.sel_s2, cfg_user_i);
      s_nxt.pend_valid = 1'b1;
    end
    if (s_r.cnt > emcs_pkg::LEN_MIN)
      s_nxt.cnt = s_r.cnt - 3'h1;
    else
    begin
      unique case (s_r.phase)
        emcs_pkg::PH_IDLE:
        begin
          if (s_r.pend_valid)
          begin
            s_nxt.lens = s_r.pend_lens;
            s_nxt.pend_valid = 1'b0;
          end
          if (req_valid_i && s_r.rdy)
          begin
            s_nxt.req = req_i;
            s_nxt.phase = emcs_pkg::PH_T1;
            s_nxt.cnt = s_nxt.lens[0];
          end
        end
        emcs_pkg::PH_T1, emcs_pkg::PH_T2, emcs_pkg::PH_T3:
        begin
          // Phase codes count up, so the code indexes the next length.
          s_nxt.phase = emcs_pkg::emcs_phase_t'(s_r.phase + 3'h1);
          s_nxt.cnt = s_r.lens[s_r.phase];
        end
        emcs_pkg::PH_T4:
        begin
          // Waits are judged in the last unit, so each adds one unit.
          if (!s_r.wait_s2)
          begin
            s_nxt.phase = emcs_pkg::PH_T5;
            s_nxt.cnt = s_r.lens[4];
          end
        end
        emcs_pkg::PH_T5:
        begin
          push = !s_r.req.write && !s_r.req.refresh;
          s_nxt.phase = emcs_pkg::PH_T6;
          s_nxt.cnt = s_r.lens[5];
        end
        emcs_pkg::PH_T6:
        begin
          s_nxt.phase = s_r.pins.pclk ? emcs_pkg::PH_PAD
                                      : emcs_pkg::PH_IDLE;
          s_nxt.cnt = emcs_pkg::LEN_MIN;
        end
        emcs_pkg::PH_PAD:
          s_nxt.phase = emcs_pkg::PH_IDLE;
      endcase
    end
    // Accept only while the clock is about to rise and read data have room.
    s_nxt.rdy = (s_nxt.phase == emcs_pkg::PH_IDLE) && !s_nxt.pins.pclk &&
                buf_ready && !push;
    // Pins follow the next phase so each changes on a unit edge.
    s_nxt.pins.rd_n = !(!s_nxt.req.write && !s_nxt.req.refresh &&
                        (s_nxt.phase == emcs_pkg::PH_T4 ||
                         s_nxt.phase == emcs_pkg::PH_T5));
    s_nxt.pins.av_n = !(s_nxt.phase inside {emcs_pkg::PH_T2, emcs_pkg::PH_T3,
                        emcs_pkg::PH_T4, emcs_pkg::PH_T5});
    s_nxt.pins.wr_n = ~(s_nxt.req.byte_en &
                        {4{s_nxt.req.write &&
                           (s_nxt.phase == emcs_pkg::PH_T4 ||
                            s_nxt.phase == emcs_pkg::PH_T5)}});
    unique case (s_nxt.phase)
      emcs_pkg::PH_IDLE:
      begin
        // Internal access display; strobes are already inactive here.
        s_nxt.pins.ad = int_i.addr;
        s_nxt.pins.wf = !int_i.write;
        s_nxt.pins.rf = 1'b1;
        s_nxt.pins.ad_oe = int_i.valid;
        s_nxt.pins.wf_oe = int_i.valid;
        s_nxt.pins.rf_oe = int_i.valid;
      end
      emcs_pkg::PH_T1, emcs_pkg::PH_T2:
      begin
        // A refresh or request cycle replaces the internal display.
        s_nxt.pins.ad = s_nxt.req.addr;
        s_nxt.pins.wf = !s_nxt.req.write;
        s_nxt.pins.rf = !s_nxt.req.refresh;
        s_nxt.pins.ad_oe = 1'b1;
        s_nxt.pins.wf_oe = 1'b1;
        s_nxt.pins.rf_oe = 1'b1;
      end
      default:
      begin
        // Reads release the bus from phase three; the memory owns it then.
        s_nxt.pins.ad = s_nxt.req.wdata[emcs_pkg::DATA_W-1:2];
        s_nxt.pins.rf = s_nxt.req.wdata[1];
        s_nxt.pins.wf = s_nxt.req.wdata[0];
        s_nxt.pins.ad_oe = s_nxt.req.write;
        s_nxt.pins.wf_oe = s_nxt.req.write;
        s_nxt.pins.rf_oe = s_nxt.req.write;
      end
    endcase
  end

  // State register; reset timing is the slowest set for slow boot memory.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_r <= '{phase: emcs_pkg::PH_IDLE, cnt: emcs_pkg::LEN_MIN,
               lens: emcs_pkg::RESET_LENS, pend_lens: emcs_pkg::RESET_LENS,
               pend_valid: 1'b0, strap_cnt: 2'h0, sel_s1: '0, sel_s2: '0,
               wait_s1: 1'b0, wait_s2: 1'b0, din_s1: '0, din_s2: '0,
               req: '0, rdy: 1'b0, pins: emcs_pkg::PINS_RESET};
    else
      s_r <= s_nxt;
  end
  assign req_ready_o = s_r.rdy;
  assign mux_addr_data_bus_o = s_r.pins.ad;
  assign mux_addr_data_bus_oe_o = s_r.pins.ad_oe;
  assign write_flag_data0_o = s_r.pins.wf;
  assign write_flag_data0_oe_o = s_r.pins.wf_oe;
  assign refresh_flag_data1_o = s_r.pins.rf;
  assign refresh_flag_data1_oe_o = s_r.pins.rf_oe;
  assign read_strobe_n_o = s_r.pins.rd_n;
  assign address_valid_strobe_n_o = s_r.pins.av_n;
  assign byte_write_strobes_n_o = s_r.pins.wr_n;
  assign processor_clock_output_o = s_r.pins.pclk;
  // Helper: units spent in the current external cycle, for the parity check.
  // Wrapping at 256 keeps the parity, so long wait runs do no harm.
  logic [7:0] units_r;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      units_r <= 8'h00;
    else
      units_r <= (s_r.phase == emcs_pkg::PH_IDLE) ? 8'h00 : units_r + 8'h01;
  end
  sequence s_t4_wait;
    s_r.phase == emcs_pkg::PH_T4 && s_r.cnt == 3'h1 && s_r.wait_s2;
  endsequence
  sequence s_cycle_start;
    s_r.phase == emcs_pkg::PH_T1 && $past(s_r.phase) == emcs_pkg::PH_IDLE;
  endsequence
  property p_len_range;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.lens[0] inside {[1:4]} && s_r.lens[3] inside {[1:4]} &&
    s_r.lens[5] inside {[1:4]};
  endproperty
  a_len_range: assert property (p_len_range)
    else $error("phase length out of range");
  property p_reset_lens;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.strap_cnt != 2'h3 |-> s_r.lens == emcs_pkg::RESET_LENS;
  endproperty
  a_reset_lens: assert property (p_reset_lens)
    else $error("reset timing not all four units");
  property p_t1_rising;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_cycle_start |-> s_r.pins.pclk && !$past(s_r.pins.pclk);
  endproperty
  a_t1_rising: assert property (p_t1_rising)
    else $error("cycle did not start on rising clock");
  // In the first idle unit the counter holds the full length of the cycle.
  property p_even_cycle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.phase != emcs_pkg::PH_IDLE ##1 s_r.phase == emcs_pkg::PH_IDLE
      |-> !units_r[0];
  endproperty
  a_even_cycle: assert property (p_even_cycle)
    else $error("external cycle has odd length");
  property p_wait_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_t4_wait |=> s_r.phase == emcs_pkg::PH_T4 && !read_strobe_n_o ==
      (!s_r.req.write && !s_r.req.refresh);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("wait did not hold phase four");
  property p_read_strobe;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(read_strobe_n_o) |-> !address_valid_strobe_n_o &&
      !$past(address_valid_strobe_n_o) && !mux_addr_data_bus_oe_o;
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("read strobe outside address valid window");
  property p_av_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(address_valid_strobe_n_o) |-> s_r.phase == emcs_pkg::PH_T2 &&
      $past(s_r.phase) == emcs_pkg::PH_T1;
  endproperty
  a_av_start: assert property (p_av_start)
    else $error("address valid strobe not at phase two");
  property p_write_data;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.req.write && s_r.phase inside {emcs_pkg::PH_T4, emcs_pkg::PH_T5,
      emcs_pkg::PH_T6, emcs_pkg::PH_PAD} |-> $stable(mux_addr_data_bus_o) &&
      mux_addr_data_bus_oe_o && write_flag_data0_o == s_r.req.wdata[0];
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write data not held");
  property p_internal;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_r.phase == emcs_pkg::PH_IDLE && $past(s_r.phase) ==
      emcs_pkg::PH_IDLE |-> refresh_flag_data1_o && read_strobe_n_o &&
      address_valid_strobe_n_o && byte_write_strobes_n_o == 4'hf;
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal display drives a strobe");

endmodule

`default_nettype wire

// ### test/emcs_mem_model.sv
// Behavioural static memory standing on the far side of the bus.
`timescale 1ns/100ps
`default_nettype none

module emcs_mem_model (
  input wire logic core_clk_i,
  input wire logic [31:0] bus_i,
  input wire logic dut_oe_i,
  input wire logic av_n_i,
  input wire logic rd_n_i,
  input wire logic [3:0] wr_n_i,
  input wire logic [3:0] wait_len_i,
  output logic [31:0] mem_d_o,
  output logic mem_oe_o,
  output logic wait_o
);
  logic [31:0] mem [16];
  logic [31:0] wdat_r = '0;
  logic [31:0] last_r = '0;
  logic [3:0] a_r = '0;
  logic [3:0] seen_r = '0;
  logic [3:0] wcnt_r = '0;
  logic av_prev_r = 1'b1;
  logic rd_cyc_r = 1'b0;

  // Known contents so that reads can be predicted by the bench.
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 32'hA5C3_0000 + 32'(i);
  end

  // The address is latched in the first unit after the valid strobe
  // falls, while it is still on the pins; both flags high mark a read.
  always @(posedge core_clk_i)
  begin
    av_prev_r <= av_n_i;
    last_r <= mem_d_o;
    if (!av_n_i && av_prev_r)
    begin
      a_r <= bus_i[5:2];
      rd_cyc_r <= bus_i[1] & bus_i[0];
    end
    // Only bytes whose strobe went low are written, at the strobe's end.
    if (wr_n_i != 4'hf)
    begin
      seen_r <= seen_r | ~wr_n_i;
      wdat_r <= bus_i;
    end
    else if (seen_r != 4'h0)
    begin
      for (int b = 0; b < 4; b++)
        if (seen_r[b])
          mem[a_r][8*b +: 8] <= wdat_r[8*b +: 8];
      seen_r <= 4'h0;
    end
    wcnt_r <= av_n_i ? 4'h0 : wcnt_r + {3'h0, !rd_n_i};
  end

  // Data goes out once the sequencer lets go and stops with the valid
  // strobe; a released bus shows the inverse of its last value, so a
  // stale word can never pass for a fresh one.
  assign mem_oe_o = rd_cyc_r && !av_n_i && !dut_oe_i;
  assign mem_d_o = mem_oe_o ? mem[a_r] : ~last_r;
  // Wait is held until the read strobe has run for the asked count.
  assign wait_o = !av_n_i && (wcnt_r < wait_len_i);
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the external memory cycle sequencer.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // Phase lengths 1,2,2,2,1,1: an odd total of nine units.
  localparam emcs_pkg::emcs_lens_t USER_LENS =
    {3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h1};
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid = 1'b0;
  logic rd_ready = 1'b1;
  logic [3:0] wait_len = 4'h0;
  emcs_pkg::emcs_req_t req = '0;
  emcs_pkg::emcs_int_t int_a = '0;
  logic req_ready, rd_valid, ad_oe, wf_o, wf_oe, rf_o, rf_oe;
  logic rd_n, av_n, pclk, mem_oe, wait_w, took, t1_pclk;
  logic [29:0] ad_o;
  logic [3:0] wr_n;
  logic [31:0] rd_data, mem_d, bus, t1_bus, t4_bus, got;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_av, n_rd, n_oe, n_wr0, n_wr1, n_pop, n_clash;

  // Wire levels come from whichever party drives each pin.
  assign bus = {ad_oe ? ad_o : mem_d[31:2], rf_oe ? rf_o : mem_d[1],
    wf_oe ? wf_o : mem_d[0]};

  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  emcs_sequencer u_emcs_sequencer (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_sel_i(4'hd),
    .cfg_user_i(USER_LENS), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_i(req), .int_i(int_a),
    .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data),
    .wait_i(wait_w), .mux_addr_data_bus_i(bus[31:2]),
    .mux_addr_data_bus_o(ad_o), .mux_addr_data_bus_oe_o(ad_oe),
    .write_flag_data0_i(bus[0]), .write_flag_data0_o(wf_o),
    .write_flag_data0_oe_o(wf_oe), .refresh_flag_data1_i(bus[1]),
    .refresh_flag_data1_o(rf_o), .refresh_flag_data1_oe_o(rf_oe),
    .read_strobe_n_o(rd_n), .address_valid_strobe_n_o(av_n),
    .byte_write_strobes_n_o(wr_n), .processor_clock_output_o(pclk));

  emcs_mem_model u_emcs_mem_model (
    .core_clk_i(core_clk_i), .bus_i(bus), .dut_oe_i(ad_oe),
    .av_n_i(av_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .wait_len_i(wait_len), .mem_d_o(mem_d), .mem_oe_o(mem_oe),
    .wait_o(wait_w));

  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One request, then a fixed window in which strobe widths are counted.
  task automatic run(input logic w, input logic rf, input logic [29:0] a,
    input logic [31:0] d, input logic [3:0] be, input logic must);
    took = 1'b0;
    req = '{addr: a, wdata: d, byte_en: be, write: w, refresh: rf};
    req_valid = 1'b1;
    for (int i = 0; i < 30 && !took; i++)
    begin
      @(negedge core_clk_i);
      took = req_ready;
    end
    @(negedge core_clk_i);
    req_valid = 1'b0;
    if (!took && must)
    begin
      n_mismatch++;
      $display("Error at %0t: request never taken", $time);
      end_of_test();
    end
    t1_bus = bus;
    t1_pclk = pclk;
    {n_av, n_rd, n_oe, n_wr0, n_wr1, n_pop, n_clash} = '0;
    for (int i = 0; i < 60 && took; i++)
    begin
      if ((!rd_n || !(&wr_n)) && n_rd + n_wr0 + n_wr1 == 0)
        t4_bus = bus;
      n_av += int'(!av_n);
      n_rd += int'(!rd_n);
      n_oe += int'(ad_oe);
      n_wr0 += int'(!wr_n[0]);
      n_wr1 += int'(!wr_n[1]);
      // Memory and sequencer must never drive a pin in the same unit.
      n_clash += int'(mem_oe && (ad_oe || rf_oe || wf_oe));
      if (rd_valid && rd_ready)
      begin
        got = rd_data;
        n_pop++;
      end
      @(negedge core_clk_i);
    end
  endtask

  // First cycle after reset runs with every phase four units long.
  task automatic t_first_write;
    run(1'b1, 1'b0, 30'h3, 32'h1234_5678, 4'h5, 1'b1);
    chk_v(t1_pclk, 1'b1);
    chk_v(t1_bus, {30'h3, 2'b10});
    chk_v(n_av, 16);
    chk_v(n_wr0, 8);
    chk_v(n_wr1, 0);
    chk_v(n_oe, 24);
    chk_v(t4_bus, 32'h1234_5678);
  endtask

  // Read back under the strapped user timing; byte merge must show.
  task automatic t_user_read;
    run(1'b0, 1'b0, 30'h3, 32'h0, 4'h0, 1'b1);
    chk_v(t1_bus, {30'h3, 2'b11});
    chk_v(n_av, 7);
    chk_v(n_rd, 3);
    chk_v(n_oe, 3);
    chk_v(got, 32'hA534_0078);
    chk_v(n_clash, 0);
  endtask

  task automatic t_pad_write;
    run(1'b1, 1'b0, 30'h7, 32'hCAFE_F00D, 4'hf, 1'b1);
    chk_v(n_oe, 10);
    chk_v(n_wr0, 3);
    chk_v(t4_bus, 32'hCAFE_F00D);
  endtask

  task automatic t_wait_read;
    wait_len = 4'h3;
    run(1'b0, 1'b0, 30'h7, 32'h0, 4'h0, 1'b1);
    wait_len = 4'h0;
    chk_v(n_rd > 3 && n_rd <= 10, 1'b1);
    chk_v(got, 32'hCAFE_F00D);
    chk_v(n_clash, 0);
  endtask

  task automatic t_refresh;
    run(1'b0, 1'b1, 30'h15, 32'h0, 4'h0, 1'b1);
    chk_v(t1_bus, {30'h15, 2'b01});
    chk_v(n_rd + n_pop, 0);
  endtask

  // Internal access is displayed while idle, then a request overrides it.
  task automatic t_internal;
    int_a = '{valid: 1'b1, addr: 30'h2A, write: 1'b1};
    repeat (4) @(negedge core_clk_i);
    chk_v(bus, {30'h2A, 2'b10});
    chk_v({ad_oe, rd_n, av_n, wr_n}, 7'h7f);
    run(1'b0, 1'b0, 30'h9, 32'h0, 4'h0, 1'b1);
    chk_v(t1_bus, {30'h9, 2'b11});
    chk_v(got, 32'hA5C3_0009);
    int_a = '0;
  endtask

  // A stalled receiver fills the buffer; the third read must wait.
  task automatic t_stall;
    int k;
    k = 0;
    rd_ready = 1'b0;
    run(1'b0, 1'b0, 30'h1, 32'h0, 4'h0, 1'b1);
    run(1'b0, 1'b0, 30'h2, 32'h0, 4'h0, 1'b1);
    run(1'b0, 1'b0, 30'h4, 32'h0, 4'h0, 1'b0);
    chk_v(took, 1'b0);
    rd_ready = 1'b1;
    for (int i = 0; i < 20 && k < 2; i++)
    begin
      if (rd_valid)
      begin
        chk_v(rd_data, 32'hA5C3_0001 + 32'(k));
        k++;
      end
      @(negedge core_clk_i);
    end
    chk_v(k, 2);
  endtask

  initial
  begin
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_first_write();
    t_user_read();
    t_pad_write();
    t_wait_read();
    t_refresh();
    t_internal();
    t_stall();
    end_of_test();
  end
endmodule
`default_nettype wire
